// [bmrf_consts.vh]
// constants for the banked mode register file
`ifndef BMRF_CONSTS_VH
`define BMRF_CONSTS_VH
// ----------------------------------------
// mode field encodings
// ----------------------------------------
`define BMRF_MODE_USER       5'h10
`define BMRF_MODE_FAST       5'h11
`define BMRF_MODE_IRQ        5'h12
`define BMRF_MODE_SUPERVISOR 5'h13
`define BMRF_MODE_ABORT      5'h17
`define BMRF_MODE_UNDEFINED_INSTRUCTION_MODE      5'h1b
`define BMRF_MODE_SYSTEM     5'h1f
// ----------------------------------------
// status word field positions
// ----------------------------------------
`define BMRF_SW_N      31
`define BMRF_SW_Z      30
`define BMRF_SW_C      29
`define BMRF_SW_V      28
`define BMRF_SW_IRQ_DIS 7
`define BMRF_SW_FIQ_DIS 6
`define BMRF_SW_STATE  5
`define BMRF_SW_MODE_HI 4
`define BMRF_SW_MODE_LO 0
// implemented bits of the status word
`define BMRF_SW_MASK   32'hf00000ff
// ----------------------------------------
// reset values and addresses
// ----------------------------------------
`define BMRF_SW_RESET  32'h000000d3
`define BMRF_VECTOR_BASE 32'h00000000
`define BMRF_PC_INDEX  4'hf
`define BMRF_LR_INDEX  4'he
`define BMRF_SP_INDEX  4'hd
`define BMRF_WORD_ALIGN 32'hfffffffc
`define BMRF_HALF_ALIGN 32'hfffffffe
`endif

// [bmrf_bank_decode.v]
// decode of mode field into bank selects
`timescale 1ns/1ps
`include "bmrf_consts.vh"
module bmrf_bank_decode (
    input  wire [4:0] mode_in,
    output reg        fast_bank_out,
    output reg  [2:0] sp_lr_bank_out,
    output reg        has_saved_out,
    output reg        privileged_out,
    output reg        mode_valid_out
);
    // ----------------------------------------
    // bank selection
    // ----------------------------------------
    // combinational so the next access sees a new mode
    always @* begin
        fast_bank_out  = 1'b0;
        sp_lr_bank_out = 3'h0;
        has_saved_out  = 1'b1;
        privileged_out = 1'b1;
        mode_valid_out = 1'b1;
        case (mode_in)
            `BMRF_MODE_USER: begin
                has_saved_out  = 1'b0;
                privileged_out = 1'b0;
            end
            `BMRF_MODE_SYSTEM: begin
                has_saved_out = 1'b0; // user bank, privileged
            end
            `BMRF_MODE_FAST: begin
                fast_bank_out  = 1'b1;
                sp_lr_bank_out = 3'h1;
            end
            `BMRF_MODE_IRQ:        sp_lr_bank_out = 3'h2;
            `BMRF_MODE_SUPERVISOR: sp_lr_bank_out = 3'h3;
            `BMRF_MODE_ABORT:      sp_lr_bank_out = 3'h4;
            `BMRF_MODE_UNDEFINED_INSTRUCTION_MODE:      sp_lr_bank_out = 3'h5;
            default: begin
                has_saved_out  = 1'b0;
                mode_valid_out = 1'b0;
            end
        endcase
    end
endmodule

// [bmrf_status_unit.v]
// current and saved status words with save and restore
`timescale 1ns/1ps
`include "bmrf_consts.vh"
module bmrf_status_unit (
    input  wire        clk_in,
    input  wire        reset_n_in,
    input  wire [2:0]  bank_in,
    input  wire        has_saved_in,
    input  wire        exc_entry_in,
    input  wire [31:0] exc_status_in,
    input  wire        exc_return_in,
    input  wire        sw_write_in,
    input  wire [31:0] sw_data_in,
    input  wire        saved_write_in,
    input  wire [31:0] saved_data_in,
    output reg  [31:0] current_status_word_out,
    output wire [31:0] saved_status_word_out
);
    reg [31:0] saved_reg [1:5];
    wire [31:0] saved_sel;
    assign saved_sel = (bank_in >= 3'h1 && bank_in <= 3'h5) ? saved_reg[bank_in] : 32'h0;
    assign saved_status_word_out = has_saved_in ? saved_sel : 32'h0;

    // ----------------------------------------
    // current status word
    // ----------------------------------------
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            current_status_word_out <= `BMRF_SW_RESET;
        end else if (exc_entry_in) begin
            current_status_word_out <= exc_status_in & `BMRF_SW_MASK;
        end else if (exc_return_in && has_saved_in) begin
            current_status_word_out <= saved_sel;
        end else if (sw_write_in) begin
            current_status_word_out <= sw_data_in & `BMRF_SW_MASK;
        end
    end

    // ----------------------------------------
    // saved status words, one per exception mode
    // ----------------------------------------
    // entry saves into the bank of the mode being entered, not the current one
    reg [2:0] entry_bank;
    always @* begin
        case (exc_status_in[`BMRF_SW_MODE_HI:`BMRF_SW_MODE_LO])
            `BMRF_MODE_FAST:       entry_bank = 3'h1;
            `BMRF_MODE_IRQ:        entry_bank = 3'h2;
            `BMRF_MODE_SUPERVISOR: entry_bank = 3'h3;
            `BMRF_MODE_ABORT:      entry_bank = 3'h4;
            `BMRF_MODE_UNDEFINED_INSTRUCTION_MODE:      entry_bank = 3'h5;
            default:               entry_bank = 3'h0;
        endcase
    end

    genvar g;
    generate
        for (g = 1; g <= 5; g = g + 1) begin : g_saved
            always @(posedge clk_in) begin
                if (exc_entry_in) begin
                    if (entry_bank == g)
                        saved_reg[g] <= current_status_word_out;
                end else if (saved_write_in && has_saved_in && bank_in == g) begin
                    saved_reg[g] <= saved_data_in & `BMRF_SW_MASK;
                end
            end
        end
    endgenerate
endmodule

// [bmrf_register_file.v]
// banked mode register file top
`timescale 1ns/1ps
`include "bmrf_consts.vh"
module bmrf_register_file (
    input  wire        clk_in,
    input  wire        reset_n_in,
    input  wire [3:0]  rd_a_index_in,
    input  wire [3:0]  rd_b_index_in,
    input  wire [3:0]  rd_c_index_in,
    input  wire        wr_en_in,
    input  wire [3:0]  wr_index_in,
    input  wire [31:0] wr_data_in,
    input  wire        pc_advance_in,
    input  wire        call_in,
    input  wire [31:0] call_target_in,
    input  wire        exc_entry_in,
    input  wire [4:0]  exc_mode_in,
    input  wire [31:0] exc_vector_offset_in,
    input  wire [31:0] exc_return_addr_in,
    input  wire        exc_return_in,
    input  wire        status_write_in,
    input  wire [31:0] status_data_in,
    input  wire        saved_write_in,
    input  wire [31:0] saved_data_in,
    input  wire [31:0] data_addr_in,
    input  wire [1:0]  data_size_in,
    output wire [31:0] rd_a_data_out,
    output wire [31:0] rd_b_data_out,
    output wire [31:0] rd_c_data_out,
    output wire [31:0] pc_out,
    output wire [31:0] current_status_word_out,
    output wire [31:0] saved_status_word_out,
    output wire [4:0]  mode_out,
    output wire        compact_state_out,
    output wire        privileged_out,
    output wire        mode_valid_out,
    output wire        has_saved_out,
    output wire        fetch_size_out,
    output wire        misaligned_out
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    reg [31:0] low_reg  [0:7];   // unbanked 0..7
    reg [31:0] user_hi_reg [8:14];
    reg [31:0] fast_hi_reg [8:12];
    reg [31:0] sp_bank_reg [1:5];
    reg [31:0] lr_bank_reg [1:5];
    reg [31:0] pc_reg;

    wire        fast_bank;
    wire [2:0]  bank;
    wire [31:0] status_word;
    wire        do_return;
    wire [2:0]  exc_bank;
    wire        exc_fast;
    wire [31:0] return_link;
    wire [31:0] step;

    assign mode_out          = status_word[`BMRF_SW_MODE_HI:`BMRF_SW_MODE_LO];
    assign compact_state_out = status_word[`BMRF_SW_STATE];
    assign current_status_word_out = status_word;
    assign do_return = exc_return_in & has_saved_out;

    // ----------------------------------------
    // mode decode for current and target mode
    // ----------------------------------------
    bmrf_bank_decode u_cur_decode (
        .mode_in        (mode_out),
        .fast_bank_out  (fast_bank),
        .sp_lr_bank_out (bank),
        .has_saved_out  (has_saved_out),
        .privileged_out (privileged_out),
        .mode_valid_out (mode_valid_out)
    );

    bmrf_bank_decode u_exc_decode (
        .mode_in        (exc_mode_in),
        .fast_bank_out  (exc_fast),
        .sp_lr_bank_out (exc_bank),
        .has_saved_out  (),
        .privileged_out (),
        .mode_valid_out ()
    );

    // ----------------------------------------
    // status words
    // ----------------------------------------
    wire [31:0] entry_status;
    assign entry_status = {status_word[31:8], 2'b11 & {1'b1, exc_fast | status_word[6]},
                           1'b0, exc_mode_in};

    bmrf_status_unit u_status (
        .clk_in                  (clk_in),
        .reset_n_in              (reset_n_in),
        .bank_in                 (bank),
        .has_saved_in            (has_saved_out),
        .exc_entry_in            (exc_entry_in),
        .exc_status_in           (entry_status),
        .exc_return_in           (exc_return_in),
        .sw_write_in             (status_write_in),
        .sw_data_in              (status_data_in),
        .saved_write_in          (saved_write_in),
        .saved_data_in           (saved_data_in),
        .current_status_word_out (status_word),
        .saved_status_word_out   (saved_status_word_out)
    );

    // ----------------------------------------
    // banked read of one index
    // ----------------------------------------
    function [31:0] read_reg;
        input [3:0] idx;
        begin
            if (idx == `BMRF_PC_INDEX)
                read_reg = pc_reg;
            else if (idx[3] == 1'b0)
                read_reg = low_reg[idx[2:0]];
            else if (idx >= `BMRF_SP_INDEX && bank != 3'h0)
                read_reg = (idx == `BMRF_SP_INDEX) ? sp_bank_reg[bank]
                                                   : lr_bank_reg[bank];
            else if (idx <= 4'hc && fast_bank)
                read_reg = fast_hi_reg[idx];
            else
                read_reg = user_hi_reg[idx];
        end
    endfunction

    // three read ports over the 16 visible registers
    assign rd_a_data_out = read_reg(rd_a_index_in);
    assign rd_b_data_out = read_reg(rd_b_index_in);
    assign rd_c_data_out = read_reg(rd_c_index_in);
    assign pc_out        = pc_reg;

    // ----------------------------------------
    // instruction width and alignment
    // ----------------------------------------
    assign fetch_size_out = ~compact_state_out;
    assign step = compact_state_out ? 32'h00000002 : 32'h00000004;
    assign misaligned_out = (data_size_in == 2'h2 && data_addr_in[1:0] != 2'h0) ||
                            (data_size_in == 2'h1 && data_addr_in[0]);
    assign return_link = pc_reg + step;

    // ----------------------------------------
    // program counter, one write per cycle
    // ----------------------------------------
    // pc advances by one step, 2 or 4 bytes, on pc_advance_in when no other pc write is taken
    always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            pc_reg <= `BMRF_VECTOR_BASE;
        end else if (exc_entry_in) begin
            pc_reg <= `BMRF_VECTOR_BASE + exc_vector_offset_in;
        end else if (do_return) begin
            pc_reg <= (bank != 3'h0) ? lr_bank_reg[bank] : user_hi_reg[14];
        end else if (call_in) begin
            pc_reg <= call_target_in;
        end else if (wr_en_in && wr_index_in == `BMRF_PC_INDEX) begin
            pc_reg <= wr_data_in;
        end else if (pc_advance_in) begin
            pc_reg <= pc_reg + step;
        end
    end

    // ----------------------------------------
    // unbanked registers
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_low
            always @(posedge clk_in) begin
                if (wr_en_in && wr_index_in == i)
                    low_reg[i] <= wr_data_in;
            end
        end
    endgenerate

    // ----------------------------------------
    // registers 8 to 12, user and fast copies
    // ----------------------------------------
    generate
        for (i = 8; i <= 12; i = i + 1) begin : g_mid
            always @(posedge clk_in) begin
                if (wr_en_in && wr_index_in == i && !fast_bank)
                    user_hi_reg[i] <= wr_data_in;
            end
            always @(posedge clk_in) begin
                if (wr_en_in && wr_index_in == i && fast_bank)
                    fast_hi_reg[i] <= wr_data_in;
            end
        end
    endgenerate

    // ----------------------------------------
    // user and system stack pointer and link
    // ----------------------------------------
    always @(posedge clk_in) begin
        if (bank == 3'h0 && wr_en_in && wr_index_in == `BMRF_SP_INDEX)
            user_hi_reg[13] <= wr_data_in;
    end

    always @(posedge clk_in) begin
        if (exc_entry_in) begin
            user_hi_reg[14] <= user_hi_reg[14];
        end else if (bank == 3'h0 && call_in) begin
            user_hi_reg[14] <= return_link;
        end else if (bank == 3'h0 && wr_en_in && wr_index_in == `BMRF_LR_INDEX) begin
            user_hi_reg[14] <= wr_data_in;
        end
    end

    // ----------------------------------------
    // exception mode stack pointer and link
    // ----------------------------------------
    generate
        for (i = 1; i <= 5; i = i + 1) begin : g_exc
            always @(posedge clk_in) begin
                if (bank == i && wr_en_in && wr_index_in == `BMRF_SP_INDEX)
                    sp_bank_reg[i] <= wr_data_in;
            end
            always @(posedge clk_in) begin
                if (exc_entry_in) begin
                    if (exc_bank == i)
                        lr_bank_reg[i] <= exc_return_addr_in;
                end else if (bank == i && call_in) begin
                    lr_bank_reg[i] <= return_link;
                end else if (bank == i && wr_en_in && wr_index_in == `BMRF_LR_INDEX) begin
                    lr_bank_reg[i] <= wr_data_in;
                end
            end
        end
    endgenerate

    // privilege of every non user mode comes from the decoder
    // storage above: 8+7+5+5+5+1 general plus 1+5 status words
endmodule

// [bmrf_core_model.sv]
// datapath side model: vector offset and return address for an entry
`timescale 1ns/1ps
`include "bmrf_consts.vh"
module bmrf_core_model (
    input  wire [4:0]  mode_in,
    input  wire [31:0] pc_in,
    output wire [31:0] vec_out,
    output wire [31:0] ret_out
);
    // each mode fetches from its own slot above the base at zero
    assign vec_out = `BMRF_VECTOR_BASE + {26'h0, mode_in[3:0], 2'b00};
    // return address is four bytes past the current pc, whatever the instruction state
    assign ret_out = pc_in + 32'h00000004;
endmodule

// [bmrf_register_file_checker.sv]
// port assertions for the banked register file
`timescale 1ns/1ps
`include "bmrf_consts.vh"
module bmrf_register_file_checker (
    input wire        clk_in,
    input wire        reset_n_in,
    input wire [3:0]  rd_a_index_in,
    input wire        wr_en_in,
    input wire        pc_advance_in,
    input wire        call_in,
    input wire [31:0] call_target_in,
    input wire        exc_entry_in,
    input wire [4:0]  exc_mode_in,
    input wire [31:0] exc_vector_offset_in,
    input wire [31:0] exc_return_addr_in,
    input wire        exc_return_in,
    input wire [31:0] data_addr_in,
    input wire [1:0]  data_size_in,
    input wire [31:0] rd_a_data_out,
    input wire [31:0] pc_out,
    input wire [31:0] current_status_word_out,
    input wire [31:0] saved_status_word_out,
    input wire [4:0]  mode_out,
    input wire        compact_state_out,
    input wire        privileged_out,
    input wire        has_saved_out,
    input wire        fetch_size_out,
    input wire        misaligned_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    AST_RESET_STATE: assert property ($rose(reset_n_in) |->
        current_status_word_out == `BMRF_SW_RESET && pc_out == 32'h0) else $error("reset state");
    AST_FIELDS: assert property (mode_out == current_status_word_out[4:0] &&
        compact_state_out == current_status_word_out[5] && fetch_size_out == !compact_state_out)
        else $error("status fields");
    AST_PRIV: assert property (privileged_out == (mode_out != `BMRF_MODE_USER))
        else $error("privilege");
    AST_SAVED_MODES: assert property (has_saved_out == (mode_out inside {
        `BMRF_MODE_FAST, `BMRF_MODE_IRQ, `BMRF_MODE_SUPERVISOR, `BMRF_MODE_ABORT,
        `BMRF_MODE_UNDEFINED_INSTRUCTION_MODE})) else $error("saved word presence");
    AST_ENTRY: assert property (exc_entry_in |=> mode_out == $past(exc_mode_in) &&
        pc_out == $past(exc_vector_offset_in) && current_status_word_out[7])
        else $error("entry mode or pc");
    AST_ENTRY_SAVE: assert property (exc_entry_in |=>
        saved_status_word_out == $past(current_status_word_out)) else $error("entry save");
    AST_ENTRY_LINK: assert property (exc_entry_in ##1 rd_a_index_in == 4'he |->
        rd_a_data_out == $past(exc_return_addr_in)) else $error("entry link");
    AST_RETURN: assert property (exc_return_in && has_saved_out && !exc_entry_in |=>
        current_status_word_out == ($past(saved_status_word_out) & `BMRF_SW_MASK))
        else $error("return status");
    AST_CALL: assert property (call_in && !exc_entry_in && !exc_return_in |=>
        pc_out == $past(call_target_in)) else $error("call target");
    AST_ADVANCE: assert property (pc_advance_in && !(exc_entry_in || exc_return_in ||
        call_in || wr_en_in) |=> pc_out == $past(pc_out) + ($past(compact_state_out) ?
        32'h2 : 32'h4)) else $error("pc step");
    AST_MISALIGN: assert property (data_size_in != 2'h3 |-> misaligned_out ==
        (data_size_in == 2'h2 ? |data_addr_in[1:0] : data_size_in == 2'h1 && data_addr_in[0]))
        else $error("alignment flag");
    cover property (exc_entry_in);
    cover property (exc_return_in && has_saved_out);
    cover property (call_in);
endmodule
bind bmrf_register_file bmrf_register_file_checker u_chk (.*);

// [tb_banked_mode_register_file.sv]
// self-checking bench for the banked mode register file
`timescale 1ns/1ps
`include "bmrf_consts.vh"
module tb_banked_mode_register_file;
    reg         clk_in, reset_n_in, wr_en_in, pc_advance_in, call_in, exc_entry_in;
    reg         exc_return_in, status_write_in, saved_write_in;
    reg  [3:0]  rd_a_index_in, rd_b_index_in, rd_c_index_in, wr_index_in, ix;
    reg  [31:0] wr_data_in, call_target_in, status_data_in, saved_data_in, data_addr_in;
    reg  [4:0]  exc_mode_in, cur;
    reg  [1:0]  data_size_in;
    wire [31:0] exc_vector_offset_in, exc_return_addr_in, rd_a_data_out, rd_b_data_out;
    wire [31:0] rd_c_data_out, pc_out, current_status_word_out, saved_status_word_out;
    wire [4:0]  mode_out;
    wire        compact_state_out, privileged_out, mode_valid_out, has_saved_out;
    wire        fetch_size_out, misaligned_out;
    integer     err_total, total_checks, i, k;
    reg  [31:0] exp_r [0:31];
    reg  [31:0] exp_sv [0:7];
    reg  [31:0] known, exp_sw, exp_pc, d;
    reg  [4:0]  modes [0:6];
    bmrf_register_file dut (.*);
    bmrf_core_model u_core (.mode_in(exc_mode_in), .pc_in(pc_out),
        .vec_out(exc_vector_offset_in), .ret_out(exc_return_addr_in));
    // ---------------------------------------
    // expectation helpers
    // ---------------------------------------
    function [2:0] bank(input [4:0] m);
        case (m)
            `BMRF_MODE_FAST:       bank = 3'd0;
            `BMRF_MODE_IRQ:        bank = 3'd1;
            `BMRF_MODE_SUPERVISOR: bank = 3'd2;
            `BMRF_MODE_ABORT:      bank = 3'd3;
            `BMRF_MODE_UNDEFINED_INSTRUCTION_MODE:      bank = 3'd4;
            default:               bank = 3'd7;
        endcase
    endfunction
    function [4:0] phys(input [4:0] m, input [3:0] r);
        if (r < 8 || bank(m) == 3'd7 || (r < 13 && bank(m) != 3'd0)) phys = {1'b0, r};
        else if (r < 13) phys = {1'b0, r} + 5'd7;
        else phys = 5'd7 + {1'b0, bank(m), 1'b0} + {1'b0, r};
    endfunction
    task chk(input [8*8-1:0] what, input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %0s exp %h seen %h", what, exp, seen);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", total_checks, err_total);
            if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
            else $display("[ FAIL ]");
            $finish;
        end
    endtask
    // one taking edge, strobes dropped, then a quiet edge
    task go;
        begin
            @(posedge clk_in);
            #1;
            {wr_en_in, pc_advance_in, call_in, exc_entry_in} = 4'h0;
            {exc_return_in, status_write_in, saved_write_in} = 3'h0;
            @(posedge clk_in);
            #1;
        end
    endtask
    task do_reset;
        begin
            reset_n_in = 1'b0;
            repeat (6) @(posedge clk_in);
            #1;
            reset_n_in = 1'b1;
            {cur, exp_sw, exp_pc, known} = {`BMRF_MODE_SUPERVISOR, `BMRF_SW_RESET, 64'h0};
            chk("rst_sw", current_status_word_out, exp_sw);
            chk("rst_pc", pc_out, exp_pc);
            chk("rst_priv", privileged_out, 1);
            $display("reset test done");
        end
    endtask
    task enter(input [4:0] m);
        begin
            exc_mode_in = m;
            rd_a_index_in = 4'he;
            #1;
            d = exc_return_addr_in;
            chk("ret_addr", d, exp_pc + 4);
            exc_entry_in = 1'b1;
            exp_sv[bank(m)] = exp_sw;
            exp_r[phys(m, 4'he)] = d;
            known[phys(m, 4'he)] = 1'b1;
            exp_pc = exc_vector_offset_in;
            exp_sw = {exp_sw[31:8], 1'b1, exp_sw[6] | (m == `BMRF_MODE_FAST), 1'b0, m};
            cur = m;
            go;
            chk("ent_pc", pc_out, exp_pc);
            chk("ent_sw", current_status_word_out, exp_sw);
            chk("ent_save", saved_status_word_out, exp_sv[bank(m)]);
            chk("ent_link", rd_a_data_out, d);
        end
    endtask
    task set_mode(input [4:0] m);
        begin
            if (cur == `BMRF_MODE_USER) enter(`BMRF_MODE_SUPERVISOR);
            if (cur != m) begin
                d = $urandom;
                status_write_in = 1'b1;
                status_data_in = {d[3:0], exp_sw[27:5], m};
                exp_sw = status_data_in;
                cur = m;
                go;
            end
            chk("mode", mode_out, m);
            chk("priv", privileged_out, m != `BMRF_MODE_USER);
            chk("has_sv", has_saved_out, bank(m) != 3'd7);
            chk("mode_ok", mode_valid_out, 1);
        end
    endtask
    task ret;
        begin
            exc_return_in = 1'b1;
            if (bank(cur) != 3'd7) begin
                exp_pc = exp_r[phys(cur, 4'he)];
                exp_sw = exp_sv[bank(cur)];
            end
            go;
            chk("ret_pc", pc_out, exp_pc);
            chk("ret_sw", current_status_word_out, exp_sw);
            cur = exp_sw[4:0];
        end
    endtask
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // cuts a hang short well past the expected thousand or so cycles
    initial begin
        #400000;
        err_total = err_total + 1;
        conclude;
    end
    initial begin
        {wr_en_in, pc_advance_in, call_in, exc_entry_in, exc_return_in} = 5'h00;
        {status_write_in, saved_write_in, rd_a_index_in, rd_b_index_in} = 10'h000;
        {rd_c_index_in, wr_index_in, exc_mode_in, data_size_in} = 15'h0000;
        {wr_data_in, call_target_in, status_data_in, saved_data_in} = 128'h0;
        data_addr_in = 32'h0;
        {err_total, total_checks} = 64'h0;
        {modes[0], modes[1], modes[2], modes[3]} = {`BMRF_MODE_USER, `BMRF_MODE_FAST,
            `BMRF_MODE_IRQ, `BMRF_MODE_SUPERVISOR};
        {modes[4], modes[5], modes[6]} = {`BMRF_MODE_ABORT, `BMRF_MODE_UNDEFINED_INSTRUCTION_MODE,
            `BMRF_MODE_SYSTEM};
        d = $urandom(32'ha811);
        do_reset;
        // random banked writes and reads across modes
        for (k = 0; k < 150; k = k + 1) begin
            set_mode(modes[$urandom % 7]);
            ix = $urandom % 15;
            {wr_en_in, wr_index_in, wr_data_in} = {1'b1, ix, $urandom};
            exp_r[phys(cur, ix)] = wr_data_in;
            known[phys(cur, ix)] = 1'b1;
            go;
            set_mode(modes[$urandom % 7]);
            {rd_a_index_in, rd_b_index_in} = {ix, 4'hf};
            rd_c_index_in = $urandom % 8;
            #1;
            if (known[phys(cur, ix)]) chk("bank_rd", rd_a_data_out, exp_r[phys(cur, ix)]);
            chk("pc_rd", rd_b_data_out, exp_pc);
            if (known[rd_c_index_in]) chk("low_rd", rd_c_data_out, exp_r[rd_c_index_in]);
        end
        $display("banking test done");
        // calls and steps in both instruction states
        for (i = 0; i < 2; i = i + 1) begin
            set_mode(`BMRF_MODE_SYSTEM);
            status_write_in = 1'b1;
            status_data_in = {exp_sw[31:6], i[0], exp_sw[4:0]};
            exp_sw = status_data_in;
            go;
            chk("fetch", fetch_size_out, i == 0);
            {call_in, call_target_in} = {1'b1, $urandom & `BMRF_HALF_ALIGN};
            exp_r[phys(cur, 4'he)] = exp_pc + (i ? 2 : 4);
            exp_pc = call_target_in;
            go;
            rd_a_index_in = 4'he;
            #1;
            chk("call_lr", rd_a_data_out, exp_r[phys(cur, 4'he)]);
            chk("call_pc", pc_out, exp_pc);
            pc_advance_in = 1'b1;
            exp_pc = exp_pc + (i ? 2 : 4);
            go;
            chk("step", pc_out, exp_pc);
        end
        $display("call test done");
        // entry and return for every exception mode
        for (k = 1; k < 6; k = k + 1) begin
            set_mode(`BMRF_MODE_SYSTEM);
            enter(modes[k]);
            if (k == 2) begin
                d = $urandom;
                saved_write_in = 1'b1;
                saved_data_in = {d[31:28], 20'h0, d[7:6], 1'b0, `BMRF_MODE_USER};
                exp_sv[bank(cur)] = saved_data_in;
                go;
            end
            ret;
        end
        set_mode(`BMRF_MODE_USER);
        ret;
        $display("exception test done");
        // alignment flag for data sizes 0 to 2
        for (k = 0; k < 24; k = k + 1) begin
            {data_addr_in, data_size_in} = {$urandom, 2'(k % 3)};
            #1;
            chk("misal", misaligned_out, data_size_in == 2 ? |data_addr_in[1:0] :
                data_size_in == 1 && data_addr_in[0]);
            @(posedge clk_in);
            #1;
        end
        $display("alignment test done");
        do_reset;
        conclude;
    end
endmodule
